//--- hdl/spm_map.svh
// Offsets, field positions, reset values and timing counts of the self-programming block
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

`define CTRL_STATUS_OFS        8'h00
`define STATUS_OFS             8'h04
`define CTRL_STATUS_RST        8'h00

`define BIT_PROGRAM_ENABLE     0
`define BIT_PAGE_ERASE         1
`define BIT_PAGE_WRITE         2
`define BIT_LOCK_BIT_SET       3
`define BIT_APP_READ_ENABLE    4
`define BIT_APP_BUSY           6
`define BIT_IRQ_ENABLE         7

`define CMD_PAGE_ERASE         5'h03
`define CMD_BUFFER_LOAD        5'h01
`define CMD_PAGE_WRITE         5'h05
`define CMD_LOCK_WRITE         5'h09
`define CMD_APP_READ_ENABLE    5'h11

`define PTR_FUSE_LOW           16'h0000
`define PTR_LOCK_BITS          16'h0001
`define PTR_FUSE_EXT           16'h0002
`define PTR_FUSE_HIGH          16'h0003

`define LOAD_WINDOW_CYCLES     3
`define STORE_WINDOW_CYCLES    4

`define PROG_TIME_MIN_US       3700
`define PROG_TIME_MAX_US       4500
`define RC_TICK_KHZ            1000
`define PROG_TICKS_MIN         ((`PROG_TIME_MIN_US * `RC_TICK_KHZ + 999) / 1000)
`define PROG_TICKS_MAX         ((`PROG_TIME_MAX_US * `RC_TICK_KHZ) / 1000)

`endif

//--- hdl/spm_pkg.sv
// Types shared by the self-programming block
package spm_pkg;
	typedef enum logic [1:0] {st_idle, st_armed, st_running} seq_state_t;
	typedef enum logic [1:0] {op_none, op_erase, op_write, op_lock} flash_op_t;
endpackage : spm_pkg

//--- hdl/program_timer.sv
// Programming-duration timer clocked by hclk and advanced by oscillator ticks
`timescale 1ns/1ps
`include "spm_map.svh"
module program_timer #(
	parameter int TICKS = `PROG_TICKS_MIN
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	input  wire logic rc_tick,
	output logic      busy,
	output logic      done
);
	localparam int CW = $clog2(TICKS + 1);
	localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

	logic [CW-1:0] tick_cnt_r;
	logic          busy_r;
	wire           last_tick = busy_r & rc_tick & (tick_cnt_r == LAST);

	// Only oscillator ticks advance the count, so the clock rate never shapes the duration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_cnt_r <= '0;
			busy_r     <= 1'b0;
		end
		else if (start && !busy_r)
		begin
			tick_cnt_r <= '0;
			busy_r     <= 1'b1;
		end
		else if (last_tick)
			busy_r <= 1'b0;
		else if (busy_r && rc_tick)
			tick_cnt_r <= tick_cnt_r + CW'(1);
	end

	assign busy = busy_r;
	assign done = last_tick;

	tick_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
		busy_r && !last_tick |=>
		busy_r && (tick_cnt_r == $past(tick_cnt_r) + CW'($past(rc_tick))))
		else $error("Programming ended before its full tick count");
endmodule : program_timer

//--- hdl/self_program_fuse_lock_access.sv
// Self-programming sequencer with fuse and lock read-back, reached over AHB-Lite
`timescale 1ns/1ps
`include "spm_map.svh"
module self_program_fuse_lock_access #(
	parameter int          PROG_TICKS = `PROG_TICKS_MIN,
	parameter logic [15:0] NO_CONCURRENT_READ_SECTION_START = 16'h3800
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sys_rst_n,
	input  wire logic        eeprom_write_active,
	input  wire logic        rc_tick,
	input  wire logic        spm_exec,
	input  wire logic        lpm_exec,
	input  wire logic [15:0] z_ptr,
	input  wire logic [15:0] spm_wdata,
	input  wire logic [7:0]  flash_rdata,
	input  wire logic [5:0]  lock_bits,
	input  wire logic [7:0]  fuse_low_byte,
	input  wire logic [7:0]  fuse_high_byte,
	input  wire logic [7:0]  fuse_extended_byte,
	output logic [7:0]       lpm_rdata,
	output logic             lpm_valid,
	output logic [15:0]      flash_rd_addr,
	output logic             flash_rd_en,
	output logic             buf_load,
	output logic             buf_clear,
	output logic [15:0]      buf_data,
	output logic [15:0]      prog_addr,
	output logic [1:0]       prog_op,
	output logic [7:0]       lock_prog_data,
	output logic             app_section_busy,
	output logic             cpu_halt,
	output logic             spm_ready_irq
);
	logic                 wr_pend_r;
	logic                 rd_pend_r;
	logic [7:0]           addr_r;
	spm_pkg::seq_state_t  state_r;
	spm_pkg::seq_state_t  state_nxt;
	spm_pkg::flash_op_t   op_r;
	logic [4:0]           cmd_r;
	logic [2:0]           win_cnt_r;
	logic                 irq_en_r;
	logic                 app_busy_r;
	logic                 halt_r;
	logic [7:0]           lpm_rdata_r;
	logic                 lpm_valid_r;
	logic                 buf_load_r;
	logic                 buf_clear_r;
	logic [15:0]          buf_data_r;
	logic [15:0]          prog_addr_r;
	logic [7:0]           lock_prog_data_r;
	logic                 timer_busy;
	logic                 timer_done;

	// Bus decode
	wire        addr_phase = hsel & hready & htrans[1];
	wire        wr_ctrl    = wr_pend_r & (addr_r == `CTRL_STATUS_OFS);
	wire [4:0]  wr_cmd     = hwdata[4:0];
	wire        armed      = (state_r == spm_pkg::st_armed);
	wire        running    = (state_r == spm_pkg::st_running);
	wire        pe_bit     = (state_r != spm_pkg::st_idle);

	// A new command is refused during an EEPROM write and while a previous one is pending
	wire cmd_ok   = wr_ctrl & ~eeprom_write_active & (state_r == spm_pkg::st_idle)
	              & wr_cmd[`BIT_PROGRAM_ENABLE];
	wire readback = (cmd_r == `CMD_LOCK_WRITE);
	wire lpm_hit  = armed & readback & lpm_exec & ~eeprom_write_active
	              & (win_cnt_r < 3'(`LOAD_WINDOW_CYCLES));
	wire spm_hit  = armed & spm_exec & (win_cnt_r < 3'(`STORE_WINDOW_CYCLES));
	wire win_end  = armed & (win_cnt_r == 3'(`STORE_WINDOW_CYCLES - 1));

	wire is_erase = spm_hit & (cmd_r == `CMD_PAGE_ERASE);
	wire is_write = spm_hit & (cmd_r == `CMD_PAGE_WRITE);
	wire is_lock  = spm_hit & (cmd_r == `CMD_LOCK_WRITE);
	wire is_load  = spm_hit & (cmd_r == `CMD_BUFFER_LOAD);
	wire is_rden  = spm_hit & (cmd_r == `CMD_APP_READ_ENABLE);
	wire is_prog  = is_erase | is_write | is_lock;
	wire in_no_concurrent_read_section  = (z_ptr >= NO_CONCURRENT_READ_SECTION_START);
	wire app_addr = ~in_no_concurrent_read_section;

	// Read-back selection by pointer
	wire [7:0] lock_byte = {2'b11, lock_bits};
	wire [7:0] readback_byte =
		(z_ptr == `PTR_LOCK_BITS) ? lock_byte :
		(z_ptr == `PTR_FUSE_LOW)  ? fuse_low_byte :
		(z_ptr == `PTR_FUSE_HIGH) ? fuse_high_byte :
		(z_ptr == `PTR_FUSE_EXT)  ? fuse_extended_byte :
		8'hff;
	// Stored values pass straight through, so zero means programmed

	// Application reads are blocked while the busy flag is set, which lasts until a read-enable clears it
	wire app_blocked = app_busy_r & app_addr;
	wire [7:0] lpm_byte = lpm_hit ? readback_byte :
	                      app_blocked ? 8'hff : flash_rdata;

	wire [7:0] ctrl_rd = {irq_en_r, app_busy_r, 1'b0,
	                      cmd_r[4] & pe_bit, cmd_r[3] & pe_bit,
	                      cmd_r[2] & pe_bit, cmd_r[1] & pe_bit, pe_bit};
	wire [7:0] stat_rd = {4'h0, eeprom_write_active, halt_r, timer_busy, armed};
	wire [31:0] rd_word = (addr_r == `CTRL_STATUS_OFS) ? {24'h0, ctrl_rd} :
	                      (addr_r == `STATUS_OFS)      ? {24'h0, stat_rd} : 32'h0;

	// Next state of the command sequencer
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			spm_pkg::st_idle:
				if (cmd_ok)
					state_nxt = spm_pkg::st_armed;
			spm_pkg::st_armed:
				if (is_prog)
					state_nxt = spm_pkg::st_running;
				else if (spm_hit || lpm_hit || win_end || !sys_rst_n)
					state_nxt = spm_pkg::st_idle;
			spm_pkg::st_running:
				if (timer_done)
					state_nxt = spm_pkg::st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end
		else
		begin
			wr_pend_r <= addr_phase & hwrite & (hsize == 3'h2);
			rd_pend_r <= addr_phase & ~hwrite;
			addr_r    <= addr_phase ? haddr[7:0] : addr_r;
		end
	end

	// A system reset returns an armed sequencer to idle unless a store starts programming in that cycle; idle and running ones ignore it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r   <= spm_pkg::st_idle;
			cmd_r     <= 5'h00;
			win_cnt_r <= 3'h0;
		end
		else
		begin
			state_r   <= state_nxt;
			cmd_r     <= cmd_ok ? wr_cmd : cmd_r;
			win_cnt_r <= cmd_ok ? 3'h0 : (armed ? win_cnt_r + 3'h1 : 3'h0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_en_r <= 1'b0;
		else if (!sys_rst_n)
			irq_en_r <= 1'b0;
		else if (wr_ctrl)
			irq_en_r <= hwdata[`BIT_IRQ_ENABLE];
	end

	// Busy sets on any erase or write, in either section, and clears only on read-enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			app_busy_r <= 1'b0;
		else if (is_erase || is_write)
			app_busy_r <= 1'b1;
		else if (is_rden && !running)
			app_busy_r <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_r        <= spm_pkg::op_none;
			halt_r      <= 1'b0;
			prog_addr_r <= 16'h0000;
		end
		else if (is_prog)
		begin
			op_r        <= is_erase ? spm_pkg::op_erase :
			               is_write ? spm_pkg::op_write : spm_pkg::op_lock;
			halt_r      <= (is_erase | is_write) & in_no_concurrent_read_section;
			prog_addr_r <= z_ptr;
		end
		else if (timer_done)
		begin
			op_r   <= spm_pkg::op_none;
			halt_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lpm_rdata_r      <= 8'hff;
			lpm_valid_r      <= 1'b0;
			buf_load_r       <= 1'b0;
			buf_clear_r      <= 1'b0;
			buf_data_r       <= 16'h0000;
			lock_prog_data_r <= 8'hff;
		end
		else
		begin
			lpm_rdata_r      <= lpm_exec ? lpm_byte : lpm_rdata_r;
			lpm_valid_r      <= lpm_exec;
			buf_load_r       <= is_load;
			// Page buffer empties on read-enable and on a system reset
			buf_clear_r      <= is_rden | ~sys_rst_n;
			buf_data_r       <= is_load ? spm_wdata : buf_data_r;
			lock_prog_data_r <= is_lock ? spm_wdata[7:0] : lock_prog_data_r;
		end
	end

	program_timer #(
		.TICKS (PROG_TICKS)
	) u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (is_prog),
		.rc_tick (rc_tick),
		.busy    (timer_busy),
		.done    (timer_done)
	);

	assign hrdata           = rd_pend_r ? rd_word : 32'h0;
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign lpm_rdata        = lpm_rdata_r;
	assign lpm_valid        = lpm_valid_r;
	assign flash_rd_addr    = z_ptr;
	assign flash_rd_en      = lpm_exec & ~lpm_hit & ~app_blocked;
	assign buf_load         = buf_load_r;
	assign buf_clear        = buf_clear_r;
	assign buf_data         = buf_data_r;
	assign prog_addr        = prog_addr_r;
	assign prog_op          = op_r;
	assign lock_prog_data   = lock_prog_data_r;
	assign app_section_busy = app_busy_r;
	assign cpu_halt         = halt_r;
	assign spm_ready_irq    = irq_en_r & ~pe_bit;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence arm_s;
		cmd_ok ##1 armed;
	endsequence

	sequence quiet_window_s;
		(!spm_exec && !lpm_exec) [*4];
	endsequence

	eeprom_refuse_a: assert property (
		wr_ctrl && eeprom_write_active && !pe_bit |=> !pe_bit)
		else $error("Command accepted during EEPROM write");

	readback_refuse_a: assert property (
		lpm_exec && eeprom_write_active && !app_blocked |=> lpm_rdata == $past(flash_rdata))
		else $error("Read-back served during EEPROM write");

	window_expiry_a: assert property (
		arm_s ##0 quiet_window_s |=> !pe_bit)
		else $error("Enable did not clear after store window");

	lock_layout_a: assert property (
		lpm_hit && z_ptr == `PTR_LOCK_BITS |=> lpm_valid && lpm_rdata == {2'b11, $past(lock_bits)})
		else $error("Lock byte layout wrong");

	fuse_low_a: assert property (
		lpm_hit && z_ptr == `PTR_FUSE_LOW |=> lpm_rdata == $past(fuse_low_byte) && !pe_bit)
		else $error("Fuse low byte not returned");

	fuse_high_ext_a: assert property (
		lpm_hit && (z_ptr == `PTR_FUSE_HIGH || z_ptr == `PTR_FUSE_EXT) |=>
		lpm_rdata == ($past(z_ptr[0]) ? $past(fuse_high_byte) : $past(fuse_extended_byte)))
		else $error("Fuse high or extended byte not returned");

	plain_read_a: assert property (
		lpm_exec && !pe_bit && !app_blocked |=> lpm_rdata == $past(flash_rdata))
		else $error("Ordinary flash read not performed");

	enable_held_a: assert property (
		timer_busy |-> ctrl_rd[`BIT_PROGRAM_ENABLE])
		else $error("Program-enable dropped while programming");

	busy_hold_a: assert property (
		app_busy_r && !is_rden |=> app_busy_r)
		else $error("Busy flag cleared without read-enable");

	app_block_a: assert property (
		lpm_exec && app_busy_r && app_addr && !lpm_hit |-> !flash_rd_en ##1 lpm_rdata == 8'hff)
		else $error("Application read not blocked");

	reset_survive_a: assert property (
		running && !sys_rst_n && !timer_done |=> running)
		else $error("System reset aborted a write");

	halt_section_a: assert property (
		(is_erase || is_write) && !in_no_concurrent_read_section |=> !cpu_halt)
		else $error("CPU halted for application-section operation");

	halt_boot_a: assert property (
		(is_erase || is_write) && in_no_concurrent_read_section |=> cpu_halt)
		else $error("CPU not halted for boot-section operation");

	load_window_a: assert property (
		armed && win_cnt_r >= 3'(`LOAD_WINDOW_CYCLES) |-> !lpm_hit)
		else $error("Read-back served after the load window");

	store_window_a: assert property (
		armed |-> win_cnt_r < 3'(`STORE_WINDOW_CYCLES))
		else $error("Armed state outlived the store window");

	readback_clear_a: assert property (
		lpm_hit |=> !pe_bit && !ctrl_rd[`BIT_LOCK_BIT_SET])
		else $error("Enable not cleared after read-back");

	busy_set_a: assert property (
		is_erase || is_write |=> app_busy_r && running && timer_busy)
		else $error("Busy flag not set on programming start");

	rden_clear_a: assert property (
		is_rden |=> !app_section_busy && buf_clear)
		else $error("Read-enable did not clear busy");

	ready_irq_a: assert property (
		timer_done && irq_en_r && sys_rst_n && !wr_ctrl |=> spm_ready_irq)
		else $error("Ready interrupt missing after programming");
endmodule : self_program_fuse_lock_access

//--- verification/cpu_core_model.sv
// CPU core model issuing store and load program-memory instructions
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic        hclk,
	input  wire logic [7:0]  lpm_rdata,
	input  wire logic        lpm_valid,
	input  wire logic [15:0] flash_rd_addr,
	input  wire logic        flash_rd_en,
	output logic             spm_exec,
	output logic             lpm_exec,
	output logic [15:0]      z_ptr,
	output logic [15:0]      spm_wdata,
	output logic [7:0]       flash_rdata
);
	logic [7:0] junk_r;
	initial
	begin
		spm_exec = 1'b0;
		lpm_exec = 1'b0;
		z_ptr = 16'h0000;
		spm_wdata = 16'h0000;
		junk_r = 8'h3c;
	end
	// Unread flash shows a changing pattern so a stray sample cannot match by luck
	always @(posedge hclk) junk_r <= ~junk_r + 8'h01;
	assign flash_rdata = flash_rd_en ? (flash_rd_addr[7:0] ^ 8'ha5) : junk_r;
	task do_spm(input logic [15:0] z, input logic [15:0] d);
		@(posedge hclk);
		spm_exec <= 1'b1;
		z_ptr <= z;
		spm_wdata <= d;
		@(posedge hclk);
		spm_exec <= 1'b0;
		z_ptr <= ~z;
		spm_wdata <= ~d;
		@(negedge hclk);
	endtask : do_spm
	task do_lpm(input logic [15:0] z, output logic [7:0] rd, output logic vld);
		@(posedge hclk);
		lpm_exec <= 1'b1;
		z_ptr <= z;
		@(posedge hclk);
		lpm_exec <= 1'b0;
		z_ptr <= ~z;
		@(negedge hclk);
		rd = lpm_rdata;
		vld = lpm_valid;
	endtask : do_lpm
endmodule : cpu_core_model

//--- verification/test_self_program_fuse_lock_access.sv
// Testbench for the self-programming sequencer
`timescale 1ns/1ps
`include "spm_map.svh"
module test_self_program_fuse_lock_access;
	localparam int         PT = 4;
	localparam int         TPER = 50;
	localparam logic [5:0] LOCKS = 6'h25;
	localparam logic [7:0] FLO = 8'h62;
	localparam logic [7:0] FHI = 8'hd9;
	localparam logic [7:0] FEXT = 8'hfd;
	localparam logic [7:0] RB_EXP [0:3] = '{FLO, {2'b11, LOCKS}, FEXT, FHI};
	logic        hclk, hresetn, hsel, hwrite, sys_rst_n, ee_act, rc_tick, tick_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, prog_op;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, spm_exec, lpm_exec, lpm_valid, flash_rd_en, vld;
	logic        buf_load, buf_clear, app_busy, cpu_halt, irq;
	logic [15:0] z_ptr, spm_wdata, flash_rd_addr, buf_data, prog_addr;
	logic [7:0]  flash_rdata, lpm_rdata, lock_prog_data, rd8;
	logic [5:0]  tick_cnt;
	int          miscompares, n_checks, n, run_cyc;

	self_program_fuse_lock_access #(.PROG_TICKS(PT)) self_program_fuse_lock_access_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_rst_n(sys_rst_n),
		.eeprom_write_active(ee_act), .rc_tick(rc_tick), .spm_exec(spm_exec),
		.lpm_exec(lpm_exec), .z_ptr(z_ptr), .spm_wdata(spm_wdata), .flash_rdata(flash_rdata),
		.lock_bits(LOCKS), .fuse_low_byte(FLO), .fuse_high_byte(FHI),
		.fuse_extended_byte(FEXT), .lpm_rdata(lpm_rdata), .lpm_valid(lpm_valid),
		.flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en), .buf_load(buf_load),
		.buf_clear(buf_clear), .buf_data(buf_data), .prog_addr(prog_addr),
		.prog_op(prog_op), .lock_prog_data(lock_prog_data), .app_section_busy(app_busy),
		.cpu_halt(cpu_halt), .spm_ready_irq(irq));
	cpu_core_model cpu_core_model_i (
		.hclk(hclk), .lpm_rdata(lpm_rdata), .lpm_valid(lpm_valid),
		.flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en), .spm_exec(spm_exec),
		.lpm_exec(lpm_exec), .z_ptr(z_ptr), .spm_wdata(spm_wdata), .flash_rdata(flash_rdata));

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// Oscillator tick every TPER cycles; pausing it must stall programming
	always @(posedge hclk)
	begin
		tick_cnt <= (tick_cnt == 6'd49) ? 6'd0 : tick_cnt + 6'd1;
		rc_tick <= tick_en && (tick_cnt == 6'd49);
		run_cyc <= (prog_op === 2'd0) ? 0 : run_cyc + 1;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task give_verdict;
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Ready is looked at just before the edge so the edge's own updates never race
	task wait_rdy(output logic [31:0] d);
		logic r;
		do
		begin
			@(negedge hclk);
			d = hrdata;
			r = hreadyout;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask : wait_rdy
	task ahb_xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy(d);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(d);
	endtask : ahb_xfer
	task ahb_wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb_xfer(1'b1, a, wd, d);
	endtask : ahb_wr
	task wait_done;
		n = 0;
		while (prog_op !== 2'd0 && n < 5000)
		begin
			@(negedge hclk);
			n++;
		end
		n = run_cyc;
	endtask : wait_done
	initial
	begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, ee_act, rc_tick, tick_cnt, hresetn} = '0;
		{sys_rst_n, tick_en, hsize} = {1'b1, 1'b1, 3'h2};
		{miscompares, n_checks, run_cyc} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ahb_xfer(1'b0, `CTRL_STATUS_OFS, 32'h0, rd);
		chk(rd, 32'h0, "ctrl reset");
		ahb_xfer(1'b0, `STATUS_OFS, 32'h0, rd);
		chk(rd | 32'(hresp), 32'h0, "status reset");
		ahb_wr(32'h08, 32'hff);
		ahb_xfer(1'b0, 32'h08, 32'h0, rd);
		chk(rd, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++)
		begin
			ahb_wr(`CTRL_STATUS_OFS, 32'h09);
			cpu_core_model_i.do_lpm(i[15:0], rd8, vld);
			chk({vld, rd8}, {1'b1, RB_EXP[i]}, "read-back");
			ahb_xfer(1'b0, `CTRL_STATUS_OFS, 32'h0, rd);
			chk(rd & 32'h09, 32'h0, "auto clear");
		end
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		@(posedge hclk);
		cpu_core_model_i.do_lpm(16'h0003, rd8, vld);
		chk(rd8, FHI, "last load cycle");
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		repeat (2) @(posedge hclk);
		cpu_core_model_i.do_lpm(16'h0001, rd8, vld);
		chk(rd8, 8'ha4, "load window over");
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		repeat (4) @(posedge hclk);
		cpu_core_model_i.do_lpm(16'h0001, rd8, vld);
		chk(rd8, 8'ha4, "window expiry");
		cpu_core_model_i.do_lpm(16'h0123, rd8, vld);
		chk(rd8, 8'h86, "plain load");
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		ee_act <= 1'b1;
		cpu_core_model_i.do_lpm(16'h0000, rd8, vld);
		chk(rd8, 8'ha5, "read-back blocked");
		@(posedge hclk);
		ahb_wr(`CTRL_STATUS_OFS, 32'h03);
		cpu_core_model_i.do_spm(16'h0100, 16'h0000);
		chk(prog_op, 2'd0, "erase blocked");
		ahb_xfer(1'b0, `STATUS_OFS, 32'h0, rd);
		chk(rd & 32'h08, 32'h08, "eeprom status");
		@(posedge hclk);
		ee_act <= 1'b0;
		ahb_wr(`CTRL_STATUS_OFS, 32'h83);
		cpu_core_model_i.do_spm(16'h0100, 16'h0000);
		chk({app_busy, cpu_halt, prog_op, irq, prog_addr}, {5'b10010, 16'h0100},
			"erase start");
		cpu_core_model_i.do_lpm(16'h0010, rd8, vld);
		chk(rd8, 8'hff, "app read blocked");
		cpu_core_model_i.do_lpm(16'h3900, rd8, vld);
		chk(rd8, 8'ha5, "boot read allowed");
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		ahb_xfer(1'b0, `CTRL_STATUS_OFS, 32'h0, rd);
		chk({rd[0], prog_op}, 3'b101, "busy refuses");
		@(posedge hclk);
		sys_rst_n <= 1'b0;
		@(posedge hclk);
		sys_rst_n <= 1'b1;
		@(negedge hclk);
		chk({prog_op, buf_clear}, 3'b011, "reset keeps erase");
		ahb_wr(`CTRL_STATUS_OFS, 32'h80);
		wait_done();
		chk(n >= (PT - 1) * TPER && n <= PT * TPER + 4, 1'b1, "erase time");
		ahb_xfer(1'b0, `CTRL_STATUS_OFS, 32'h0, rd);
		chk(rd & 32'h41, 32'h40, "busy holds");
		chk(irq, 1'b1, "ready irq");
		ahb_wr(`CTRL_STATUS_OFS, 32'h11);
		cpu_core_model_i.do_spm(16'h0000, 16'h0000);
		chk({app_busy, buf_clear}, 2'b01, "read enable");
		ahb_wr(`CTRL_STATUS_OFS, 32'h05);
		cpu_core_model_i.do_spm(16'h3800, 16'h0000);
		chk({cpu_halt, prog_op}, 3'b110, "boot write halts");
		wait_done();
		chk(n >= (PT - 1) * TPER && n <= PT * TPER + 4, 1'b1, "write time");
		chk(cpu_halt, 1'b0, "halt released");
		ahb_wr(`CTRL_STATUS_OFS, 32'h11);
		cpu_core_model_i.do_spm(16'h0000, 16'h0000);
		ahb_wr(`CTRL_STATUS_OFS, 32'h01);
		cpu_core_model_i.do_spm(16'h0002, 16'hbeef);
		chk({buf_load, buf_data}, {1'b1, 16'hbeef}, "buffer load");
		ahb_wr(`CTRL_STATUS_OFS, 32'h09);
		cpu_core_model_i.do_spm(16'h0001, 16'h00c3);
		chk({prog_op, lock_prog_data}, {2'd3, 8'hc3}, "lock write");
		@(posedge hclk);
		tick_en <= 1'b0;
		repeat (400) @(posedge hclk);
		chk(prog_op, 2'd3, "no tick no finish");
		tick_en <= 1'b1;
		wait_done();
		chk(prog_op, 2'd0, "lock write done");
		give_verdict();
	end
endmodule : test_self_program_fuse_lock_access
